//--- dcrm_top.sv
// Control register and channel monitor of a multichannel DAC
//
// Operation
// - Special functions need register select zero
// - Address 001100: write or read control
// - Bit 13: power-down high-Z or 100k
// - Bit 12: reference 2.5 V or 1.25 V
// - Bit 11: amplifier boost, default off
// - Bit 10: internal reference, default external
// - Bit 9 set: monitor routes selected channel
// - Bit 9 clear: last pin normal output
// - Bit 8: thermal shutdown over 130 C
// - Power-up re-enables only when cool
// - Address 001001: soft power-up, data ignored
// - Bits 7, 1, 0 have no effect
// - Bits 6..2 enable toggle per group
// - Group map: bit 2 channels 0-7 upward
// - Update strobe switches A and B
// - Address 001010: monitor channel in 13..8
// - Addresses 0-39 route that channel
// - Address 63 three-states monitor pin
`timescale 1ns/10ps
module dcrm_top
  import dcrm_pkg::*;
#(
  parameter int         NUM_CH     = DCRM_NUM_CH, // Channel count
  parameter logic       REF_2V5    = 1'b1         // Variant reference level
)(
  input  wire logic              clk_i,           // Clock
  input  wire logic              rst_n_i,         // Async reset, active low
  input  wire logic              cmd_valid_i,     // Command strobe
  input  wire logic              cmd_rnw_i,       // 1 read, 0 write
  input  wire logic [1:0]        cmd_reg_i,       // Register select
  input  wire logic [5:0]        cmd_addr_i,      // Address field
  input  wire logic [13:0]       cmd_data_i,      // Data field
  input  wire logic              over_temp_i,     // Die above 130 C
  input  wire logic              output_update_strobe_i, // Update pulse
  output logic      [13:0]       rd_data_o,       // Readback data
  output logic                   rd_valid_o,      // Readback valid pulse
  output logic      [13:0]       device_control_o,// Control register
  output logic                   amp_powered_o,   // Amplifiers on
  output logic                   pd_high_z_o,     // Power-down high-Z
  output logic                   ref_2v5_o,       // 2.5 V reference level
  output logic                   boost_o,         // Amplifier boost
  output logic                   int_ref_o,       // Internal reference on
  output logic      [NUM_CH-1:0] toggle_en_o,     // Per-channel toggle
  output logic      [NUM_CH-1:0] sel_b_o,         // Per-channel B select
  output logic                   mon_route_o,     // Monitor mux active
  output logic      [5:0]        mon_channel_o,   // Monitored channel
  output logic                   mon_high_z_o     // Monitor pin three-state
);
  dcrm_cmd_if cmd ();  // Decoded command

  // Reset value with the variant's reference level folded in
  localparam logic [13:0] CTRL_INIT =
    DCRM_CTRL_RESET | (14'(REF_2V5) << DCRM_POS_REFLVL);

  logic [13:0]       ctrl;        // Control register
  logic [13:0]       next_ctrl;
  logic [5:0]        mon_addr;    // Last monitor address
  logic [5:0]        next_mon_addr;
  logic              mon_cmd;     // A monitor command was seen
  logic              next_mon_cmd;
  logic              soft_pd;     // Soft power-down latched
  logic              next_soft_pd;
  logic              therm_pd;    // Thermal shutdown latched
  logic              next_therm_pd;
  logic [13:0]       rd_data;
  logic [13:0]       next_rd_data;
  logic              rd_valid;
  logic              next_rd_valid;
  logic [NUM_CH-1:0] tgl;         // Expanded toggle enables
  logic [NUM_CH-1:0] sel_b;       // From toggle unit

  // Group decode is used for the toggle enables only; the toggle unit decodes groups itself
  function automatic logic [NUM_CH-1:0] grp_expand(input logic [4:0] g);
    logic [NUM_CH-1:0] r;
    r = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      r[i] = g[i / DCRM_GRP_SIZE];
    end
    return r;
  endfunction

  dcrm_decode u_decode (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .cmd_valid_i (cmd_valid_i),
    .cmd_rnw_i   (cmd_rnw_i),
    .cmd_reg_i   (cmd_reg_i),
    .cmd_addr_i  (cmd_addr_i),
    .cmd_data_i  (cmd_data_i),
    .cmd         (cmd)
  );

  dcrm_toggle #(.NUM_CH(NUM_CH)) u_toggle (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .grp_en_i (ctrl[DCRM_POS_TGL_LO +: DCRM_NUM_GRP]),
    .update_i (output_update_strobe_i),
    .sel_b_o  (sel_b)
  );

  // Control register, monitor selection and readback
  always_comb begin
    next_ctrl     = ctrl;
    next_mon_addr = mon_addr;
    next_mon_cmd  = mon_cmd;
    next_rd_valid = 1'b0;
    next_rd_data  = rd_data;
    if (cmd.ctrl_wr) begin
      // Whole field stored; spare bits steer nothing
      next_ctrl = cmd.data;
    end
    if (cmd.ctrl_rd) begin
      next_rd_data  = ctrl;
      next_rd_valid = 1'b1;
    end
    if (cmd.mon_wr) begin
      // Low eight data bits are ignored
      // Addresses 40 to 62 pass through; their routing is undefined
      next_mon_addr = cmd.data[DCRM_MON_LO +: 6];
      next_mon_cmd  = 1'b1;
    end
  end

  // Power state: thermal trip and soft power-down/up
  always_comb begin
    next_soft_pd  = soft_pd;
    next_therm_pd = therm_pd;
    if (cmd.pdown) begin
      next_soft_pd = 1'b1;
    end
    if (cmd.pup) begin
      next_soft_pd = 1'b0;
      // Clears the trip only when the die has cooled
      if (!over_temp_i) begin
        next_therm_pd = 1'b0;
      end
    end
    // Trip beats a same-cycle power-up so an event is never lost
    if (ctrl[DCRM_POS_THERM] && over_temp_i) begin
      next_therm_pd = 1'b1;
    end
  end

  // State registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl     <= CTRL_INIT;
      mon_addr <= DCRM_MON_RESET;
      mon_cmd  <= 1'b0;
      soft_pd  <= 1'b0;
      therm_pd <= 1'b0;
      rd_data  <= '0;
      rd_valid <= 1'b0;
    end else begin
      ctrl     <= next_ctrl;
      mon_addr <= next_mon_addr;
      mon_cmd  <= next_mon_cmd;
      soft_pd  <= next_soft_pd;
      therm_pd <= next_therm_pd;
      rd_data  <= next_rd_data;
      rd_valid <= next_rd_valid;
    end
  end

  assign tgl = grp_expand(ctrl[DCRM_POS_TGL_LO +: DCRM_NUM_GRP]);

  // Outputs registered once more so every port leaves a flip-flop
  // Costs a cycle of latency, but no port ever shows a decode glitch
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      device_control_o <= CTRL_INIT;
      amp_powered_o    <= 1'b1;
      pd_high_z_o      <= 1'b1;
      ref_2v5_o        <= REF_2V5;
      boost_o          <= 1'b0;
      int_ref_o        <= 1'b0;
      toggle_en_o      <= '0;
      sel_b_o          <= '0;
      mon_route_o      <= 1'b0;
      mon_channel_o    <= DCRM_MON_RESET;
      mon_high_z_o     <= 1'b0;
      rd_data_o        <= '0;
      rd_valid_o       <= 1'b0;
    end else begin
      device_control_o <= ctrl;
      amp_powered_o    <= !(soft_pd || therm_pd);
      pd_high_z_o      <= ctrl[DCRM_POS_PDSTATE];
      ref_2v5_o        <= ctrl[DCRM_POS_REFLVL];
      boost_o          <= ctrl[DCRM_POS_BOOST];
      int_ref_o        <= ctrl[DCRM_POS_INTREF];
      toggle_en_o      <= tgl;
      sel_b_o          <= sel_b;
      // Routing needs enable and a prior monitor command
      mon_route_o      <= ctrl[DCRM_POS_MONEN] && mon_cmd;
      mon_channel_o    <= mon_addr;
      mon_high_z_o     <= ctrl[DCRM_POS_MONEN] && mon_cmd
                          && mon_addr == DCRM_MON_TRIST;
      rd_data_o        <= rd_data;
      rd_valid_o       <= rd_valid;
    end
  end

  // Write lands in the exposed register two edges later
  a_ctrl_write: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    cmd.ctrl_wr |=> ##1 (device_control_o == $past(cmd.data, 2)))
    else $error("control write not stored");

  // Only a write may change the stored control word
  a_ctrl_hold: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    !cmd.ctrl_wr |=> (ctrl == $past(ctrl)))
    else $error("control word changed without write");

  // Readback carries the word held when the read was taken
  a_read_back: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    cmd.ctrl_rd |-> ##2 (rd_valid_o && rd_data_o == $past(ctrl, 2)))
    else $error("readback mismatch");

  // No read taken means no readback pulse two edges on
  a_rd_pulse: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    !cmd.ctrl_rd |-> ##2 !rd_valid_o)
    else $error("readback pulse without read");

  // Power-down state follows its bit one edge behind
  a_pd_state: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    ##1 (pd_high_z_o == $past(ctrl[DCRM_POS_PDSTATE])))
    else $error("power-down state wrong");

  // Reference level and source follow their bits
  a_ref_level: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    ##1 (ref_2v5_o == $past(ctrl[DCRM_POS_REFLVL])
         && int_ref_o == $past(ctrl[DCRM_POS_INTREF])))
    else $error("reference select wrong");

  // Boost follows its bit
  a_boost_bit: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    ##1 (boost_o == $past(ctrl[DCRM_POS_BOOST])))
    else $error("boost wrong");

  // An enabled trip removes amplifier power two edges on
  a_therm_trip: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    (ctrl[DCRM_POS_THERM] && over_temp_i) |-> ##2 !amp_powered_o)
    else $error("thermal trip missed");

  // A hot power-up must leave the trip latched
  a_hot_pup: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    (therm_pd && cmd.pup && over_temp_i) |=> therm_pd)
    else $error("power-up while hot");

  // A cool power-up restores amplifier power
  a_pup_cool: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    (cmd.pup && !over_temp_i) |-> ##2 amp_powered_o)
    else $error("power-up did not restore amplifiers");

  // Disabled monitor keeps the last pin a normal output
  a_mon_off: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    !ctrl[DCRM_POS_MONEN] |=> (!mon_route_o && !mon_high_z_o))
    else $error("monitor active while disabled");

  // An enabled monitor command routes the selected channel
  a_mon_route: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    (cmd.mon_wr && ctrl[DCRM_POS_MONEN]) |-> ##2 mon_route_o)
    else $error("monitor command did not route");

  // No routing before the first monitor command
  a_route_cmd: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    !mon_cmd |=> !mon_route_o)
    else $error("routing without monitor command");

  // Address 63 three-states the monitor pin
  a_mon_trist: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    (cmd.mon_wr && cmd.data[13:8] == DCRM_MON_TRIST
     && ctrl[DCRM_POS_MONEN]) |-> ##2 mon_high_z_o)
    else $error("address 63 not three-state");

  // Monitored channel follows the command two edges on
  a_mon_addr: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    cmd.mon_wr |-> ##2 (mon_channel_o == $past(cmd.data[13:8], 2)))
    else $error("monitor channel wrong");

  // Disabled lowest group forces channel zero back to A
  a_tgl_off: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    !ctrl[DCRM_POS_TGL_LO] |=> !sel_b[0])
    else $error("disabled group left on B");

  // End groups map to the end channels
  a_group_map: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    ##1 (toggle_en_o[39] == $past(ctrl[6])
         && toggle_en_o[0] == $past(ctrl[2])))
    else $error("toggle group map wrong");
endmodule

//--- dcrm_pkg.sv
// Package with command codes, control register layout and reset values
package dcrm_pkg;
  localparam int          DCRM_DATA_W     = 14;  // Data field width
  localparam int          DCRM_ADDR_W     = 6;   // Address field width
  localparam int          DCRM_NUM_CH     = 40;  // Channel count
  localparam int          DCRM_NUM_GRP    = 5;   // Toggle groups
  localparam int          DCRM_GRP_SIZE   = 8;   // Channels per group
  localparam logic [1:0]  DCRM_REGSEL_SFR = 2'h0; // Special function select
  localparam logic [5:0]  DCRM_CMD_NOP    = 6'h00; // No operation
  localparam logic [5:0]  DCRM_CMD_PDOWN  = 6'h08; // Soft power-down
  localparam logic [5:0]  DCRM_CMD_PUP    = 6'h09; // Soft power-up
  localparam logic [5:0]  DCRM_CMD_MON    = 6'h0A; // Channel monitor
  localparam logic [5:0]  DCRM_CMD_CTRL   = 6'h0C; // Control write/read
  // Control register field positions
  localparam int          DCRM_POS_PDSTATE = 13; // Power-down output state
  localparam int          DCRM_POS_REFLVL  = 12; // Reference level
  localparam int          DCRM_POS_BOOST   = 11; // Amplifier boost
  localparam int          DCRM_POS_INTREF  = 10; // Internal reference
  localparam int          DCRM_POS_MONEN   = 9;  // Monitor enable
  localparam int          DCRM_POS_THERM   = 8;  // Thermal shutdown enable
  localparam int          DCRM_POS_TGL_LO  = 2;  // Lowest toggle group bit
  localparam int          DCRM_MON_LO      = 8;  // Monitor address field
  // Reset value; reference level follows the variant parameter
  localparam logic [13:0] DCRM_CTRL_RESET  = 14'h2000;
  localparam logic [5:0]  DCRM_MON_TRIST   = 6'h3F; // Three-state address
  localparam logic [5:0]  DCRM_MON_RESET   = 6'h3F; // Monitor idle address
endpackage

//--- dcrm_cmd_if.sv
// Interface carrying one decoded special-function command between modules
`timescale 1ns/10ps
interface dcrm_cmd_if;
  logic        ctrl_wr;   // Control register write pulse
  logic        ctrl_rd;   // Control register read pulse
  logic        mon_wr;    // Channel monitor pulse
  logic        pup;       // Soft power-up pulse
  logic        pdown;     // Soft power-down pulse
  logic [13:0] data;      // Data field
  modport src (output ctrl_wr, ctrl_rd, mon_wr, pup, pdown, data);
  modport dst (input  ctrl_wr, ctrl_rd, mon_wr, pup, pdown, data);
endinterface

//--- dcrm_decode.sv
// Special-function command decoder
`timescale 1ns/10ps
module dcrm_decode
  import dcrm_pkg::*;
(
  input  wire logic        clk_i,      // Clock
  input  wire logic        rst_n_i,    // Async reset, active low
  input  wire logic        cmd_valid_i,// Command strobe
  input  wire logic        cmd_rnw_i,  // 1 read, 0 write
  input  wire logic [1:0]  cmd_reg_i,  // Register select high/low
  input  wire logic [5:0]  cmd_addr_i, // Address field
  input  wire logic [13:0] cmd_data_i, // Data field
  dcrm_cmd_if.src          cmd         // Decoded command
);
  logic is_sfr; // Special-function space selected
  // Only register select zero reaches special functions
  assign is_sfr = cmd_valid_i && (cmd_reg_i == DCRM_REGSEL_SFR);

  // Decode is combinational; the top registers every effect
  always_comb begin
    cmd.ctrl_wr = is_sfr && cmd_addr_i == DCRM_CMD_CTRL && !cmd_rnw_i;
    cmd.ctrl_rd = is_sfr && cmd_addr_i == DCRM_CMD_CTRL && cmd_rnw_i;
    cmd.mon_wr  = is_sfr && cmd_addr_i == DCRM_CMD_MON && !cmd_rnw_i;
    cmd.pup     = is_sfr && cmd_addr_i == DCRM_CMD_PUP && !cmd_rnw_i;
    cmd.pdown   = is_sfr && cmd_addr_i == DCRM_CMD_PDOWN && !cmd_rnw_i;
    cmd.data    = cmd_data_i;
  end

  // Write carrying a non-SPECIAL_FUNCTION_COMMAND select must never hit control paths
  a_sfr_gate: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    (cmd_reg_i != DCRM_REGSEL_SFR) |-> !(cmd.ctrl_wr || cmd.mon_wr))
    else $error("decode fired outside special space");
endmodule

//--- dcrm_toggle.sv
// Per-channel A/B toggle selection driven by the update strobe
`timescale 1ns/10ps
module dcrm_toggle
  import dcrm_pkg::*;
#(
  parameter int NUM_CH = DCRM_NUM_CH  // Channel count
)(
  input  wire logic              clk_i,     // Clock
  input  wire logic              rst_n_i,   // Async reset, active low
  input  wire logic [4:0]        grp_en_i,  // Toggle group enables
  input  wire logic              update_i,  // Update strobe pulse
  output logic      [NUM_CH-1:0] sel_b_o    // 1 selects B register
);
  logic [NUM_CH-1:0] sel_b;      // Current selection
  logic [NUM_CH-1:0] next_sel_b; // Next selection

  // Each channel flips on update when its group enables toggle
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      if (!grp_en_i[i / DCRM_GRP_SIZE]) begin
        next_sel_b[i] = 1'b0;                 // Disabled: A only
      end else if (update_i) begin
        next_sel_b[i] = !sel_b[i];
      end else begin
        next_sel_b[i] = sel_b[i];
      end
    end
  end

  // Register the selection
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sel_b <= '0;
    end else begin
      sel_b <= next_sel_b;
    end
  end

  assign sel_b_o = sel_b;

  // Channel zero must swap on every update strobe while its group is enabled
  a_toggle_flip: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    (update_i && grp_en_i[0]) |=> (sel_b[0] != $past(sel_b[0])))
    else $error("enabled channel did not toggle");
endmodule

//--- dcrm_host_model.sv
// Host controller model that issues special-function command words
`timescale 1ns/10ps
module dcrm_host_model (
  input  wire logic        clk_i,        // Clock
  output logic             cmd_valid_o,  // Command strobe
  output logic             cmd_rnw_o,    // 1 read, 0 write
  output logic [1:0]       cmd_reg_o,    // Register select
  output logic [5:0]       cmd_addr_o,   // Address field
  output logic [13:0]      cmd_data_o    // Data field
);
  // Idle lines at time zero, strobe low
  initial begin
    cmd_valid_o = 1'b0;
    cmd_rnw_o   = 1'b0;
    cmd_reg_o   = 2'h3;
    cmd_addr_o  = 6'h00;
    cmd_data_o  = 14'h0000;
  end

  // One word per strobe, launched and released on falling edges
  task automatic send(input logic rnw, input logic [1:0] rs,
                      input logic [5:0] a, input logic [13:0] d);
    @(negedge clk_i);
    cmd_valid_o = 1'b1;
    cmd_rnw_o   = rnw;
    cmd_reg_o   = rs;
    cmd_addr_o  = a;
    cmd_data_o  = d;
    @(negedge clk_i);
    // Released lines flip so a stale word can never look fresh
    cmd_valid_o = 1'b0;
    cmd_rnw_o   = ~rnw;
    cmd_reg_o   = ~rs;
    cmd_addr_o  = ~a;
    cmd_data_o  = ~d;
  endtask
endmodule

//--- dcrm_tb_top.sv
// Self-checking bench for the control register and channel monitor
`timescale 1ns/10ps
module dcrm_tb_top
  import dcrm_pkg::*;
;
  localparam logic REF_V = 1'b0;  // Low-reference variant under test
  logic        clk_i = 1'b0, rst_n_i = 1'b0;      // Clock and reset
  logic        over_temp_i = 1'b0;                // Die temperature flag
  logic        output_update_strobe_i = 1'b0;     // Toggle strobe
  logic        cv, crnw;                          // Host strobe, direction
  logic [1:0]  creg;                              // Host register select
  logic [5:0]  caddr, mon_channel_o;              // Address, monitor
  logic [13:0] cdata, rd_data_o, device_control_o; // Data words
  logic        rd_valid_o, amp_powered_o, pd_high_z_o, ref_2v5_o;
  logic        boost_o, int_ref_o, mon_route_o, mon_high_z_o;
  logic [39:0] toggle_en_o, sel_b_o;              // Per-channel outputs
  logic [13:0] m_ctrl, m_rd, d;                   // Model register, read
  logic        m_amp, m_seen;                     // Model amp, monitor seen
  logic [5:0]  m_mon;                             // Model monitor address
  logic [39:0] m_selb;                            // Model B selects
  logic [5:0]  mch [6] = '{6'h00, 6'h01, 6'h14, 6'h27, 6'h3F, 6'h07};
  int          fails = 0, tests_run = 0, seed = 32'hDD1C;

  dcrm_host_model dcrm_host_model_inst (.clk_i, .cmd_valid_o(cv),
    .cmd_rnw_o(crnw), .cmd_reg_o(creg), .cmd_addr_o(caddr),
    .cmd_data_o(cdata));
  dcrm_top #(.REF_2V5(REF_V)) dcrm_top_inst (.clk_i, .rst_n_i,
    .cmd_valid_i(cv), .cmd_rnw_i(crnw), .cmd_reg_i(creg),
    .cmd_addr_i(caddr), .cmd_data_i(cdata), .over_temp_i,
    .output_update_strobe_i, .rd_data_o, .rd_valid_o, .device_control_o,
    .amp_powered_o, .pd_high_z_o, .ref_2v5_o, .boost_o, .int_ref_o,
    .toggle_en_o, .sel_b_o, .mon_route_o, .mon_channel_o, .mon_high_z_o);

  // Free-running 100 MHz clock
  always #5 clk_i = ~clk_i;

  // Group enable bit 2+g fans out to channels 8g..8g+7
  function automatic logic [39:0] tgl(input logic [13:0] c);
    for (int i = 0; i < 40; i++) tgl[i] = c[2 + i / 8];
  endfunction

  // Single compare, widened so one task serves every output
  task automatic chk(input string n, input logic [39:0] e,
                     input logic [39:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  // Visible state except readback data against the model
  task automatic chk_state;
    if (m_ctrl[8] && over_temp_i) m_amp = 1'b0;
    chk("rd_valid", 40'h0, 40'(rd_valid_o));
    chk("control", 40'(m_ctrl), 40'(device_control_o));
    chk("powered", 40'(m_amp), 40'(amp_powered_o));
    chk("pd_high_z", 40'(m_ctrl[13]), 40'(pd_high_z_o));
    chk("ref_2v5", 40'(m_ctrl[12]), 40'(ref_2v5_o));
    chk("boost", 40'(m_ctrl[11]), 40'(boost_o));
    chk("int_ref", 40'(m_ctrl[10]), 40'(int_ref_o));
    chk("toggle_en", tgl(m_ctrl), toggle_en_o);
    chk("sel_b", m_selb, sel_b_o);
    chk("mon_route", 40'(m_ctrl[9] && m_seen), 40'(mon_route_o));
    chk("mon_channel", 40'(m_mon), 40'(mon_channel_o));
    chk("mon_high_z", 40'(m_ctrl[9] && m_seen && m_mon == 6'h3F),
        40'(mon_high_z_o));
  endtask

  // Issue one command, update the model, check answer and state
  task automatic cmd(input logic rnw, input logic [1:0] rs,
                     input logic [5:0] a, input logic [13:0] dd);
    dcrm_host_model_inst.send(rnw, rs, a, dd);
    if (rs == DCRM_REGSEL_SFR) begin
      if (a == DCRM_CMD_CTRL && !rnw) m_ctrl = dd;
      if (a == DCRM_CMD_CTRL && rnw) m_rd = m_ctrl;
      if (a == DCRM_CMD_MON && !rnw) begin
        m_mon  = dd[13:8];
        m_seen = 1'b1;
      end
      if (a == DCRM_CMD_PUP && !rnw) m_amp = !(m_ctrl[8] && over_temp_i);
      if (a == DCRM_CMD_PDOWN && !rnw) m_amp = 1'b0;
    end
    // A disabled group falls back to its A register
    m_selb &= tgl(m_ctrl);
    // Readback pulse stands between the first and second edge after
    @(negedge clk_i);
    chk("rd_valid", 40'(rnw && rs == 2'h0 && a == DCRM_CMD_CTRL),
        40'(rd_valid_o));
    chk("rd_data", 40'(m_rd), 40'(rd_data_o));
    @(negedge clk_i);
    chk_state;
  endtask

  // Pulse the update strobe and expect enabled channels to swap
  task automatic pulse;
    @(negedge clk_i);
    output_update_strobe_i = 1'b1;
    @(negedge clk_i);
    output_update_strobe_i = 1'b0;
    m_selb ^= tgl(m_ctrl);
    repeat (3) @(negedge clk_i);
    chk_state;
  endtask

  // Reset held ten cycles; defaults checked while it is held
  task automatic do_reset;
    @(negedge clk_i);
    rst_n_i = 1'b0;
    m_ctrl  = DCRM_CTRL_RESET | {1'b0, REF_V, 12'h000};
    m_amp   = 1'b1;
    m_seen  = 1'b0;
    m_mon   = DCRM_MON_RESET;
    m_selb  = '0;
    m_rd    = '0;
    repeat (10) @(negedge clk_i);
    chk_state;
    rst_n_i = 1'b1;
  endtask

  // Verdict and end of run
  task automatic report_and_stop;
    if (fails == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    do_reset;
    // Random words with the monitor kept off, each read back
    repeat (10) begin
      d = 14'($random(seed)) & 14'h3DFF;
      cmd(1'b0, 2'h0, DCRM_CMD_CTRL, d);
      cmd(1'b1, 2'h0, DCRM_CMD_CTRL, 14'h0000);
    end
    // Other register selects, reads elsewhere, unknown address
    for (int r = 1; r < 4; r++) begin
      cmd(1'b0, 2'(r), DCRM_CMD_CTRL, 14'h0155);
    end
    cmd(1'b1, 2'h1, DCRM_CMD_CTRL, 14'h0000);
    cmd(1'b1, 2'h0, DCRM_CMD_MON, 14'h0000);
    cmd(1'b0, 2'h0, 6'h15, 14'h1234);
    // Monitor enabled first, then channels, boundaries and 63
    cmd(1'b0, 2'h0, DCRM_CMD_CTRL, 14'h0200);
    foreach (mch[i]) begin
      d = {mch[i], 8'($random(seed))};
      cmd(1'b0, 2'h0, DCRM_CMD_MON, d);
    end
    cmd(1'b0, 2'h0, DCRM_CMD_CTRL, 14'h0000);
    // Heat with shutdown off, then on, then recovery
    over_temp_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk_state;
    cmd(1'b0, 2'h0, DCRM_CMD_CTRL, 14'h0100);
    cmd(1'b0, 2'h0, DCRM_CMD_PUP, 14'h0000);
    over_temp_i = 1'b0;
    repeat (3) @(negedge clk_i);
    chk_state;
    cmd(1'b0, 2'h0, DCRM_CMD_PUP, 14'h3FFF);
    cmd(1'b0, 2'h0, DCRM_CMD_PDOWN, 14'h0000);
    cmd(1'b0, 2'h0, DCRM_CMD_PUP, 14'h0000);
    // Toggle groups: fixed pattern then random masks
    cmd(1'b0, 2'h0, DCRM_CMD_CTRL, 14'h0014);
    repeat (3) pulse;
    cmd(1'b0, 2'h0, DCRM_CMD_CTRL, 14'h0004);
    repeat (6) begin
      cmd(1'b0, 2'h0, DCRM_CMD_CTRL, 14'($random(seed)) & 14'h007C);
      pulse;
    end
    // Reset in mid-run restores every default
    do_reset;
    // First command after the second release reads the defaults back
    cmd(1'b1, 2'h0, DCRM_CMD_CTRL, 14'h0000);
    report_and_stop;
  end

  // Watchdog, far beyond the few hundred cycles the run needs
  initial begin
    #(5000 * 10);
    fails++;
    report_and_stop;
  end
endmodule
